// ==== sfl_pkg.sv ====
// package for the status flag logic: register map, field layout, op codes and carriers
// Operation
// - carry set on addition carry out or subtraction borrow, else cleared.
// - half carry set on carry or borrow across the low nibble boundary.
// - addition sets signed range flag when carry into top bit differs from carry out.
// - subtraction sets signed range flag when borrow into bit 7 differs from borrow out of bit 7.
// - multiply sets signed range flag when the product exceeds ff, else clears.
// - divide always clears the signed range flag.
// - parity flag is one when the accumulator holds an odd count of ones.
// - carry, half carry, signed range and parity flags clear on every reset.
// - add, add with carry, subtract update three flags; adjust, rotates, compare update carry.
// - multiply and divide zero carry; set and clear force it; bit ops load result.
// - special registers occupy direct addresses 80 to ff, reached by direct addressing only.
// - bit access allowed only on special registers whose address ends in 0 or 8.
// - all status flags live in one status word at special address d0.
// - two status bits pick one of four banks of eight working registers.
package sfl_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [7:0] SFL_ADDR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] SFL_ADDR_MAIN_OPERAND = 8'he0;
  localparam logic [7:0] SFL_SFR_BASE = 8'h80;
  localparam logic [7:0] SFL_STATUS_RESET = 8'h00;
  localparam logic [7:0] SFL_OPERAND_RESET = 8'h00;
  localparam logic [7:0] SFL_BYTE_MAX = 8'hff;

  // ***************************************************
  // status word field positions
  // ***************************************************
  localparam int SFL_BIT_CARRY = 7;
  localparam int SFL_BIT_HALF = 6;
  localparam int SFL_BIT_USER_A = 5;
  localparam int SFL_BIT_BANK_HI = 4;
  localparam int SFL_BIT_BANK_LO = 3;
  localparam int SFL_BIT_RANGE = 2;
  localparam int SFL_BIT_USER_B = 1;
  localparam int SFL_BIT_PARITY = 0;
  localparam logic [3:0] SFL_BIT_ADDR_NIB0 = 4'h0;
  localparam logic [3:0] SFL_BIT_ADDR_NIB8 = 4'h8;
  localparam int SFL_BANK_SIZE = 8;

  // ***************************************************
  // flag-affecting operations
  // ***************************************************
  typedef enum logic [3:0] {
    SFL_OP_NONE          = 4'h0,
    SFL_OP_ADD           = 4'h1,
    SFL_OP_ADD_CARRY     = 4'h2,
    SFL_OP_SUB_BORROW    = 4'h3,
    SFL_OP_PRODUCT       = 4'h4,
    SFL_OP_DIVIDE        = 4'h5,
    SFL_OP_CARRY_RESULT  = 4'h6,
    SFL_OP_FORCE_ONE     = 4'h7,
    SFL_OP_FORCE_ZERO    = 4'h8,
    SFL_OP_INVERT_CARRY  = 4'h9
  } sfl_op_type;

  // instruction result handed to the flag logic at write-back
  typedef struct packed {
    logic       valid;
    sfl_op_type op;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [7:0] prod_hi;
    logic       carry_result;
  } sfl_result_type;

  // direct-address register access
  typedef struct packed {
    logic       wr;
    logic       bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
    logic       bit_val;
  } sfl_access_type;

  // flags of the status word
  typedef struct packed {
    logic carry;
    logic half;
    logic user_a;
    logic bank_hi;
    logic bank_lo;
    logic range;
    logic user_b;
    logic parity;
  } sfl_flags_type;

endpackage : sfl_pkg

// ==== sfl_arith.sv ====
// arithmetic flag generator for add, add with carry and subtract with borrow
`timescale 1ns/1ps
module sfl_arith (
  // operands
  input  wire logic [7:0] opa_in,
  input  wire logic [7:0] opb_in,
  input  wire logic       cin_in,
  input  wire logic       sub_in,
  // flags
  output logic            carry_out,
  output logic            half_out,
  output logic            range_out
);

  logic [4:0] low_sum;
  logic [7:0] low7_sum;
  logic [8:0] full_sum;
  logic       into_top;

  // borrow logic mirrors carry: a - b - c
  always_comb begin
    if (sub_in) begin
      low_sum  = {1'b0, opa_in[3:0]} - {1'b0, opb_in[3:0]} - {4'h0, cin_in};
      low7_sum = {1'b0, opa_in[6:0]} - {1'b0, opb_in[6:0]} - {7'h00, cin_in};
      full_sum = {1'b0, opa_in} - {1'b0, opb_in} - {8'h00, cin_in};
    end else begin
      low_sum  = {1'b0, opa_in[3:0]} + {1'b0, opb_in[3:0]} + {4'h0, cin_in};
      low7_sum = {1'b0, opa_in[6:0]} + {1'b0, opb_in[6:0]} + {7'h00, cin_in};
      full_sum = {1'b0, opa_in} + {1'b0, opb_in} + {8'h00, cin_in};
    end
    into_top  = low7_sum[7];
    carry_out = full_sum[8];
    half_out  = low_sum[4];
    range_out = into_top ^ full_sum[8];
  end

endmodule : sfl_arith

// ==== sfl_bitaddr.sv ====
// special register address and bit-access decoder
`timescale 1ns/1ps
module sfl_bitaddr (
  // address
  input  wire logic [7:0] addr_in,
  // decode
  output logic            sfr_out,
  output logic            bit_ok_out
);

  // upper half only, low digit 0 or 8
  always_comb begin
    sfr_out    = addr_in >= sfl_pkg::SFL_SFR_BASE;
    bit_ok_out = sfr_out && ((addr_in[3:0] == sfl_pkg::SFL_BIT_ADDR_NIB0) ||
                             (addr_in[3:0] == sfl_pkg::SFL_BIT_ADDR_NIB8));
  end

endmodule : sfl_bitaddr

// ==== sfl_status_flag_logic.sv ====
// status word flag logic with accumulator and special register access
`timescale 1ns/1ps
module sfl_status_flag_logic (
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    srst_in,
  // instruction result at write-back
  input  wire sfl_pkg::sfl_result_type result_in,
  input  wire logic                    acc_we_in,
  input  wire logic [7:0]              acc_wdata_in,
  // direct register access
  input  wire sfl_pkg::sfl_access_type access_in,
  input  wire logic                    rd_in,
  // outputs
  output logic [7:0]                   rdata_out,
  output logic                         rd_hit_out,
  output logic                         bit_refused_out,
  output sfl_pkg::sfl_flags_type       flags_out,
  output logic [7:0]                   acc_out,
  output logic [4:0]                   bank_base_out
);

  // ***************************************************
  // state
  // ***************************************************
  sfl_pkg::sfl_flags_type flags;
  sfl_pkg::sfl_flags_type next_flags;
  logic [7:0]             acc;
  logic [7:0]             next_acc;
  logic                   bit_refused;
  logic                   next_bit_refused;

  // helpers
  logic                   ar_carry;
  logic                   ar_half;
  logic                   ar_range;
  logic                   is_sfr;
  logic                   bit_ok;
  logic                   is_sub;
  logic                   cin;
  logic [7:0]             psw_write;
  logic [7:0]             acc_after_bit;

  // byte parity, used for the next accumulator value
  function automatic logic sfl_parity(input logic [7:0] v);
    sfl_parity = ^v;
  endfunction : sfl_parity

  // place one bit into a byte
  function automatic logic [7:0] sfl_set_bit(input logic [7:0] v, input logic [2:0] idx,
                                             input logic b);
    logic [7:0] r;
    r      = v;
    r[idx] = b;
    sfl_set_bit = r;
  endfunction : sfl_set_bit

  // ***************************************************
  // submodules
  // ***************************************************
  assign is_sub = (result_in.op == sfl_pkg::SFL_OP_SUB_BORROW);
  assign cin    = (result_in.op == sfl_pkg::SFL_OP_ADD) ? 1'b0 : flags.carry;

  sfl_arith u_arith (
    .opa_in    (result_in.opa),
    .opb_in    (result_in.opb),
    .cin_in    (cin),
    .sub_in    (is_sub),
    .carry_out (ar_carry),
    .half_out  (ar_half),
    .range_out (ar_range)
  );

  sfl_bitaddr u_bitaddr (
    .addr_in    (access_in.addr),
    .sfr_out    (is_sfr),
    .bit_ok_out (bit_ok)
  );

  // ***************************************************
  // next-state
  // ***************************************************
  always_comb begin
    next_flags       = flags;
    next_acc         = acc;
    next_bit_refused = 1'b0;
    psw_write        = 8'h00;
    acc_after_bit    = 8'h00;
    // software access: byte or bit, direct addressing
    if (access_in.wr && (access_in.addr == sfl_pkg::SFL_ADDR_STATUS_WORD)) begin
      psw_write = access_in.wdata;
    end else if (access_in.bit_wr && bit_ok &&
                 (access_in.addr == sfl_pkg::SFL_ADDR_STATUS_WORD)) begin
      psw_write = sfl_set_bit(flags, access_in.bit_sel, access_in.bit_val);
    end else begin
      psw_write = flags;
    end
    if ((access_in.wr || (access_in.bit_wr && bit_ok)) &&
        (access_in.addr == sfl_pkg::SFL_ADDR_STATUS_WORD)) begin
      // parity bit ignored on writes
      next_flags.carry   = psw_write[sfl_pkg::SFL_BIT_CARRY];
      next_flags.half    = psw_write[sfl_pkg::SFL_BIT_HALF];
      next_flags.user_a  = psw_write[sfl_pkg::SFL_BIT_USER_A];
      next_flags.bank_hi = psw_write[sfl_pkg::SFL_BIT_BANK_HI];
      next_flags.bank_lo = psw_write[sfl_pkg::SFL_BIT_BANK_LO];
      next_flags.range   = psw_write[sfl_pkg::SFL_BIT_RANGE];
      next_flags.user_b  = psw_write[sfl_pkg::SFL_BIT_USER_B];
    end
    if (access_in.bit_wr && !bit_ok) begin
      next_bit_refused = 1'b1;
    end
    // accumulator writes
    if (access_in.wr && (access_in.addr == sfl_pkg::SFL_ADDR_MAIN_OPERAND)) begin
      next_acc = access_in.wdata;
    end else if (access_in.bit_wr && bit_ok &&
                 (access_in.addr == sfl_pkg::SFL_ADDR_MAIN_OPERAND)) begin
      acc_after_bit = sfl_set_bit(acc, access_in.bit_sel, access_in.bit_val);
      next_acc      = acc_after_bit;
    end
    if (acc_we_in) begin
      next_acc = acc_wdata_in;
    end
    // instruction flag update, committed with write-back
    if (result_in.valid) begin
      case (result_in.op)
        sfl_pkg::SFL_OP_ADD, sfl_pkg::SFL_OP_ADD_CARRY, sfl_pkg::SFL_OP_SUB_BORROW: begin
          next_flags.carry = ar_carry;
          next_flags.half  = ar_half;
          next_flags.range = ar_range;
        end
        sfl_pkg::SFL_OP_PRODUCT: begin
          next_flags.carry = 1'b0;
          next_flags.range = (result_in.prod_hi != 8'h00);
        end
        sfl_pkg::SFL_OP_DIVIDE: begin
          next_flags.carry = 1'b0;
          next_flags.range = 1'b0;
        end
        sfl_pkg::SFL_OP_CARRY_RESULT: begin
          next_flags.carry = result_in.carry_result;
        end
        sfl_pkg::SFL_OP_FORCE_ONE: begin
          next_flags.carry = 1'b1;
        end
        sfl_pkg::SFL_OP_FORCE_ZERO: begin
          next_flags.carry = 1'b0;
        end
        sfl_pkg::SFL_OP_INVERT_CARRY: begin
          next_flags.carry = ~flags.carry;
        end
        default: begin
          next_flags.carry = next_flags.carry;
        end
      endcase
    end
    // parity tracks the accumulator as committed
    next_flags.parity = sfl_parity(next_acc);
  end

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      flags       <= sfl_pkg::SFL_STATUS_RESET;
      acc         <= sfl_pkg::SFL_OPERAND_RESET;
      bit_refused <= 1'b0;
    end else begin
      flags       <= next_flags;
      acc         <= next_acc;
      bit_refused <= next_bit_refused;
    end
  end

  // ***************************************************
  // outputs
  // ***************************************************
  always_comb begin
    rdata_out  = 8'h00;
    rd_hit_out = 1'b0;
    if (rd_in && is_sfr && (access_in.addr == sfl_pkg::SFL_ADDR_STATUS_WORD)) begin
      rdata_out  = flags;
      rd_hit_out = 1'b1;
    end else if (rd_in && is_sfr && (access_in.addr == sfl_pkg::SFL_ADDR_MAIN_OPERAND)) begin
      rdata_out  = acc;
      rd_hit_out = 1'b1;
    end
  end

  assign flags_out       = flags;
  assign acc_out         = acc;
  assign bit_refused_out = bit_refused;
  // bank base address in scratchpad: bank times eight
  assign bank_base_out   = {flags.bank_hi, flags.bank_lo, 3'h0};

endmodule : sfl_status_flag_logic

// ==== sfl_props.sv ====
// assertions on the status flag logic ports
`timescale 1ns/1ps
module sfl_props (
  // clock and reset
  input wire logic                    clock_in,
  input wire logic                    srst_in,
  // inputs
  input wire sfl_pkg::sfl_result_type result_in,
  input wire logic                    acc_we_in,
  input wire logic [7:0]              acc_wdata_in,
  input wire sfl_pkg::sfl_access_type access_in,
  input wire logic                    rd_in,
  // outputs
  input wire logic [7:0]              rdata_out,
  input wire logic                    rd_hit_out,
  input wire logic                    bit_refused_out,
  input wire sfl_pkg::sfl_flags_type  flags_out,
  input wire logic [7:0]              acc_out,
  input wire logic [4:0]              bank_base_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // ***************************************************
  // helper sums of the operands one cycle back
  // ***************************************************
  wire logic [4:0] vo = {result_in.valid, result_in.op};
  logic [8:0]      s_q, d_q;
  logic [4:0]      hs_q, hd_q;
  logic [7:0]      s7_q, d7_q;
  logic            bad_q;
  // register sums, differences and the refusal cause
  always_ff @(posedge clock_in) begin
    s_q   <= 9'(result_in.opa) + 9'(result_in.opb);
    hs_q  <= 5'(result_in.opa[3:0]) + 5'(result_in.opb[3:0]);
    s7_q  <= 8'(result_in.opa[6:0]) + 8'(result_in.opb[6:0]);
    d_q   <= 9'(result_in.opa) - 9'(result_in.opb) - 9'(flags_out.carry);
    hd_q  <= 5'(result_in.opa[3:0]) - 5'(result_in.opb[3:0]) - 5'(flags_out.carry);
    d7_q  <= 8'(result_in.opa[6:0]) - 8'(result_in.opb[6:0]) - 8'(flags_out.carry);
    bad_q <= access_in.bit_wr && (!access_in.addr[7] || access_in.addr[2:0] != 3'h0);
  end
  // ***************************************************
  // properties
  // ***************************************************
  property p_reset; disable iff (1'b0) srst_in |=> flags_out == 8'h00; endproperty
  a_reset: assert property (p_reset) else $error("flags not cleared by reset");
  property p_parity; flags_out.parity == ^acc_out; endproperty
  a_parity: assert property (p_parity) else $error("parity does not follow accumulator");
  property p_add; vo == 5'h11 |=> flags_out.carry == s_q[8] && flags_out.half == hs_q[4]
    && flags_out.range == (s_q[8] ^ s7_q[7]); endproperty
  a_add: assert property (p_add) else $error("add flags wrong");
  property p_sub; vo == 5'h13 |=> flags_out.carry == d_q[8] && flags_out.half == hd_q[4]
    && flags_out.range == (d_q[8] ^ d7_q[7]); endproperty
  a_sub: assert property (p_sub) else $error("subtract flags wrong");
  property p_mul; vo == 5'h14 |=> !flags_out.carry && flags_out.range == ($past(result_in.prod_hi) != 8'h00);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply flags wrong");
  property p_div; vo == 5'h15 |=> !flags_out.carry && !flags_out.range; endproperty
  a_div: assert property (p_div) else $error("divide flags wrong");
  property p_cres; vo == 5'h16 |=> flags_out.carry == $past(result_in.carry_result)
    && flags_out.half == $past(flags_out.half) && flags_out.range == $past(flags_out.range); endproperty
  a_cres: assert property (p_cres) else $error("carry only op touched other flags");
  property p_one; vo == 5'h17 |=> flags_out.carry; endproperty
  a_one: assert property (p_one) else $error("set carry failed");
  property p_inv; vo == 5'h19 |=> flags_out.carry != $past(flags_out.carry); endproperty
  a_inv: assert property (p_inv) else $error("invert carry failed");
  property p_refuse; bit_refused_out == bad_q; endproperty
  a_refuse: assert property (p_refuse) else $error("bit refusal wrong");
  property p_bank; bank_base_out == {flags_out.bank_hi, flags_out.bank_lo, 3'h0}; endproperty
  a_bank: assert property (p_bank) else $error("bank base wrong");
  property p_bank_wr; access_in.wr && access_in.addr == 8'hd0
    |=> bank_base_out == {$past(access_in.wdata[4:3]), 3'h0}; endproperty
  a_bank_wr: assert property (p_bank_wr) else $error("bank bits not written");
  property p_zero; vo == 5'h18 |=> !flags_out.carry; endproperty
  a_zero: assert property (p_zero) else $error("clear carry failed");
  property p_read; rd_in |-> rdata_out == (access_in.addr == 8'hd0 ? flags_out
    : access_in.addr == 8'he0 ? acc_out : 8'h00); endproperty
  a_read: assert property (p_read) else $error("read data wrong");
  // main scenarios seen
  c_add: cover property (vo == 5'h11);
  c_refuse: cover property (bit_refused_out);
  c_read: cover property (rd_in && rd_hit_out);
endmodule : sfl_props
bind sfl_status_flag_logic sfl_props u_props (.clock_in(clock_in), .srst_in(srst_in), .result_in(result_in),
  .acc_we_in(acc_we_in), .acc_wdata_in(acc_wdata_in), .access_in(access_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .rd_hit_out(rd_hit_out), .bit_refused_out(bit_refused_out),
  .flags_out(flags_out), .acc_out(acc_out), .bank_base_out(bank_base_out));

// ==== testbench.sv ====
// self-checking bench for the status flag logic
`timescale 1ns/1ps
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module testbench;
  // ***************************************************
  // stimulus, outputs and model state
  // ***************************************************
  logic                    clock_in = 1'b0;
  logic                    srst_in = 1'b1;
  sfl_pkg::sfl_result_type res = '0;
  sfl_pkg::sfl_access_type acs = '0;
  logic                    acc_we = 1'b0;
  logic [7:0]              acc_wd = 8'h00;
  logic                    rd = 1'b0;
  logic [7:0]              rdata, acc_q, m, macc;
  logic [4:0]              bank_q;
  logic                    rd_hit, refused;
  sfl_pkg::sfl_flags_type  flags;
  logic [7:0]              ads [6] = '{8'hd0, 8'he0, 8'hd1, 8'h40, 8'h88, 8'h85};
  int                      failures = 0;
  int                      total_checks = 0;
  int                      seed = 48171;
  int                      i, o, a, b;
  // clock at 125 MHz
  always #4 clock_in = ~clock_in;
  sfl_status_flag_logic DUT (.clock_in(clock_in), .srst_in(srst_in), .result_in(res), .acc_we_in(acc_we),
    .acc_wdata_in(acc_wd), .access_in(acs), .rd_in(rd), .rdata_out(rdata), .rd_hit_out(rd_hit),
    .bit_refused_out(refused), .flags_out(flags), .acc_out(acc_q), .bank_base_out(bank_q));
  // ***************************************************
  // tasks
  // ***************************************************
  task automatic check_state(input logic bad);
    `CHK("status word", {m[7:1], ^macc}, flags)
    `CHK("accumulator", macc, acc_q)
    `CHK("parity", ^macc, flags.parity)
    `CHK("bank base", {m[4:3], 3'h0}, bank_q)
    `CHK("refused", bad, refused)
  endtask : check_state
  task automatic do_reset(input int n);
    @(posedge clock_in);
    srst_in <= 1'b1;
    repeat (n) @(posedge clock_in);
    srst_in <= 1'b0;
    m = 8'h00;
    macc = 8'h00;
    #1 check_state(1'b0);
  endtask : do_reset
  // one instruction result with the model flag update
  task automatic do_op(input int o, a, b, p, r);
    int s, ci;
    ci = (o == 1) ? 0 : m[7];
    @(posedge clock_in);
    res <= {1'b1, o[3:0], a[7:0], b[7:0], p[7:0], r[0]};
    if (o < 3) begin
      s = a + b + ci;
      m[7] = s > 255;
      m[6] = a % 16 + b % 16 + ci > 15;
      m[2] = ((a ^ s) & (b ^ s) & 128) != 0;
    end else if (o == 3) begin
      s = a - b - ci;
      m[7] = s < 0;
      m[6] = a % 16 < b % 16 + ci;
      m[2] = ((a ^ b) & (a ^ s) & 128) != 0;
    end else if (o < 6) begin
      m[7] = 0;
      m[2] = o == 4 && p != 0;
    end else m[7] = o == 6 ? r[0] : o == 7 ? 1 : o == 8 ? 0 : !m[7];
    @(posedge clock_in);
    res <= '0;
    #1 check_state(1'b0);
  endtask : do_op
  // software byte or bit write, or accumulator write-back
  task automatic put(input logic w, bw, we, input logic [7:0] ad, input logic [2:0] bs, input logic [7:0] wd,
                     input logic bv);
    logic ok;
    ok = ad[7] && ad[2:0] == 3'h0;
    @(posedge clock_in);
    acs <= {w, bw, ad, bs, wd, bv};
    acc_we <= we;
    acc_wd <= wd;
    if (we || (w && ad == 8'he0)) macc = wd;
    if (w && ad == 8'hd0) m = wd;
    if (bw && ok && ad == 8'hd0 && bs != 3'h0) m[bs] = bv;
    if (bw && ok && ad == 8'he0) macc[bs] = bv;
    @(posedge clock_in);
    acs <= '0;
    acc_we <= 1'b0;
    #1 check_state(bw && !ok);
  endtask : put
  task automatic rd_chk(input logic [7:0] ad);
    @(posedge clock_in);
    acs <= {2'b00, ad, 12'h000};
    rd <= 1'b1;
    #1;
    `CHK("read hit", ad == 8'hd0 || ad == 8'he0, rd_hit)
    `CHK("read data", ad == 8'hd0 ? {m[7:1], ^macc} : ad == 8'he0 ? macc : 8'h00, rdata)
    @(posedge clock_in);
    rd <= 1'b0;
    acs <= '0;
  endtask : rd_chk
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    do_reset(16);
    do_op(1, 255, 1, 0, 0);
    do_op(3, 0, 1, 0, 0);
    do_op(3, 128, 1, 0, 0);
    do_op(4, 0, 0, 1, 0);
    for (i = 0; i < 120; i++) begin
      o = 1 + $unsigned($random(seed)) % 9;
      a = $random(seed) & 255;
      b = $random(seed) & 255;
      do_op(o, a, b, (i % 3 == 0) ? 0 : b, a);
      if (i % 6 == 0) put(0, 0, 1, 8'h00, 3'h0, a[7:0] ^ b[7:0], 0);
    end
    put(1, 0, 0, 8'hd0, 3'h0, 8'hff, 0);
    put(1, 0, 0, 8'he0, 3'h0, 8'h5a, 0);
    for (i = 0; i < 36; i++) begin
      a = $random(seed);
      put(0, 1, 0, ads[i % 6], a[2:0], 8'h00, a[3]);
      rd_chk(ads[i % 6]);
      rd_chk(a[15:8]);
    end
    do_reset(2);
    finish_test();
  end
  // hang guard, 50000 cycles
  initial begin
    #400000;
    failures++;
    finish_test();
  end
endmodule : testbench
